// file: design/periph_frontend_pkg.sv
// Package with register map, reset values and carrier types of the peripheral front end
// Summary of operation
// - Registers are reached only as whole 32-bit words.
// - Byte or half-word accesses drop low address bits and act as word accesses.
// - Window is 16 Kbyte, or 4 Kbyte for the interrupt controller variant.
// - Control register is write-only; a one fires its command, zero does nothing.
// - Mode register is read/write configuration, zero after reset.
// - Status register is read-only current state; writes leave it unchanged.
// - Enable write sets status bits, disable write clears them, zeros change nothing.
// - Unused register bits read as zero; software writes zero into them.
// - Interrupt source is OR of status bits each ANDed with its mask bit.
// - Mask is read back, set via enable register, cleared via disable register.
// - Each channel has a 32-bit address pointer and 16-bit count register.
// - Eight channels: one receive and one transmit per serial peripheral.
// - Channel reaching its programmed amount raises an end-of-transfer condition.
// - One channel moves up to 65535 contiguous units of UNIT_BYTES bytes without processor help.
package periph_frontend_pkg;

    // Window sizes in address bits
    localparam int WIN_BITS_PERIPH = 14;
    localparam int WIN_BITS_IRQ_CTRL = 12;

    // Register word offsets inside the window
    localparam logic [13:0] OFF_CTRL = 14'h0000;
    localparam logic [13:0] OFF_MODE = 14'h0004;
    localparam logic [13:0] OFF_STAT = 14'h0008;
    localparam logic [13:0] OFF_SHADOW_EN = 14'h000c;
    localparam logic [13:0] OFF_SHADOW_DIS = 14'h0010;
    localparam logic [13:0] OFF_SHADOW_ST = 14'h0014;
    localparam logic [13:0] OFF_IRQ_EN = 14'h0018;
    localparam logic [13:0] OFF_IRQ_DIS = 14'h001c;
    localparam logic [13:0] OFF_IRQ_MASK = 14'h0020;
    localparam logic [13:0] OFF_CHAN_BASE = 14'h0100;
    localparam logic [13:0] OFF_CHAN_PTR = 14'h0000;
    localparam logic [13:0] OFF_CHAN_CNT = 14'h0004;
    localparam int CHAN_STRIDE_SHIFT = 3;

    // Field layout of the status word, plus shadow and count widths
    localparam int CORE_STAT_W = 16;
    localparam int EOT_LSB = 16;
    localparam int NUM_CHAN = 8;
    localparam int SHADOW_W = 16;
    localparam int CNT_W = 16;

    // Values after reset
    localparam logic [31:0] MODE_RST = 32'h0000_0000;
    localparam logic [31:0] MASK_RST = 32'h0000_0000;
    localparam logic [31:0] PTR_RST = 32'h0000_0000;
    localparam logic [15:0] CNT_RST = 16'h0000;

    // Access sizes on the bus request
    typedef enum logic [1:0] {
        SIZE_BYTE = 2'b00,
        SIZE_HALF = 2'b01,
        SIZE_WORD = 2'b10
    } acc_size_t;

    // One bus request, held for one cycle
    typedef struct packed {
        logic valid;
        logic write;
        acc_size_t size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } bus_req_t;

    // One buffered unit heading for memory
    typedef struct packed {
        logic [2:0] chan;
        logic [31:0] addr;
        logic [31:0] data;
    } xfer_word_t;

endpackage : periph_frontend_pkg

// file: design/peripheral_reg_frontend.sv
// Register front end with shadow bits, interrupt masking and eight transfer channels
`timescale 1ns/100ps
`default_nettype none
module peripheral_reg_frontend #(
    parameter logic [31:0] BASE_ADDR = 32'hfffc_0000,
    parameter bit IS_IRQ_CTRL = 1'b0,
    parameter logic [31:0] UNIT_BYTES = 32'h0000_0001,
    parameter int BUF_DEPTH = 2
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    // Register bus
    input wire periph_frontend_pkg::bus_req_t bus_req_in,
    output logic bus_ack_out,
    output logic bus_hit_out,
    output logic [31:0] bus_rdata_out,
    // Peripheral core side
    input wire logic [periph_frontend_pkg::CORE_STAT_W-1:0] core_status_in,
    output logic [31:0] cmd_pulse_out,
    output logic [31:0] mode_out,
    output logic [periph_frontend_pkg::SHADOW_W-1:0] shadow_status_out,
    output logic irq_source_out,
    // Transfer data from the peripheral core
    input wire logic core_valid_in,
    input wire logic [2:0] core_chan_in,
    input wire logic [31:0] core_data_in,
    output logic core_ready_out,
    output logic [periph_frontend_pkg::NUM_CHAN-1:0] chan_active_out,
    // Transfer data toward memory
    output logic mem_valid_out,
    output periph_frontend_pkg::xfer_word_t mem_word_out,
    input wire logic mem_ready_in
);

    localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
    localparam int NC = periph_frontend_pkg::NUM_CHAN;

    // Reset release through two flops; assertion stays asynchronous
    logic rst_sync1_r;
    logic rst_sync2_r;
    logic rst_n;

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_sync1_r <= 1'b0;
            rst_sync2_r <= 1'b0;
        end else begin
            rst_sync1_r <= 1'b1;
            rst_sync2_r <= rst_sync1_r;
        end
    end
    assign rst_n = rst_sync2_r;

    // Address decode; sub-word sizes are folded onto the aligned word
    logic [31:0] win_mask;
    logic [13:0] word_off;
    logic hit;
    logic wr_hit;
    logic rd_hit;

    assign win_mask = IS_IRQ_CTRL ? 32'hffff_f000 : 32'hffff_c000;
    assign hit = bus_req_in.valid && ((bus_req_in.addr & win_mask) == (BASE_ADDR & win_mask));
    // Only word lanes exist, so the low two bits are never looked at
    assign word_off = {bus_req_in.addr[13:2], 2'b00} & ~win_mask[13:0];
    assign wr_hit = hit && bus_req_in.write;
    assign rd_hit = hit && !bus_req_in.write;

    // Register write strobes
    logic wr_ctrl;
    logic wr_mode;
    logic wr_sh_en;
    logic wr_sh_dis;
    logic wr_irq_en;
    logic wr_irq_dis;
    logic chan_space;
    logic [2:0] chan_sel;
    logic [13:0] chan_field;

    assign wr_ctrl = wr_hit && (word_off == periph_frontend_pkg::OFF_CTRL);
    assign wr_mode = wr_hit && (word_off == periph_frontend_pkg::OFF_MODE);
    assign wr_sh_en = wr_hit && (word_off == periph_frontend_pkg::OFF_SHADOW_EN);
    assign wr_sh_dis = wr_hit && (word_off == periph_frontend_pkg::OFF_SHADOW_DIS);
    assign wr_irq_en = wr_hit && (word_off == periph_frontend_pkg::OFF_IRQ_EN);
    assign wr_irq_dis = wr_hit && (word_off == periph_frontend_pkg::OFF_IRQ_DIS);
    assign chan_space = (word_off[13:6] == periph_frontend_pkg::OFF_CHAN_BASE[13:6]);
    assign chan_sel = word_off[5:3];
    assign chan_field = {11'h000, word_off[2:0]};

    // Command pulses, one cycle wide, only for bits written as one
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            cmd_pulse_out <= 32'h0000_0000;
        end else begin
            cmd_pulse_out <= wr_ctrl ? bus_req_in.wdata : 32'h0000_0000;
        end
    end

    // Mode register
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            mode_out <= periph_frontend_pkg::MODE_RST;
        end else if (wr_mode) begin
            mode_out <= bus_req_in.wdata;
        end
    end

    // Shadow status bits; the clear term is applied last so disable wins
    logic [periph_frontend_pkg::SHADOW_W-1:0] sh_set;
    logic [periph_frontend_pkg::SHADOW_W-1:0] sh_clr;

    assign sh_set = wr_sh_en ? bus_req_in.wdata[periph_frontend_pkg::SHADOW_W-1:0] : '0;
    assign sh_clr = wr_sh_dis ? bus_req_in.wdata[periph_frontend_pkg::SHADOW_W-1:0] : '0;

    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            shadow_status_out <= '0;
        end else begin
            shadow_status_out <= (shadow_status_out | sh_set) & ~sh_clr;
        end
    end

    // Interrupt mask, written only through set and clear words, read back at its own word
    logic [31:0] irq_mask_r;
    logic [31:0] irq_set;
    logic [31:0] irq_clr;
    logic [31:0] stat_word;
    logic [31:0] stat_used;
    logic [NC-1:0] eot_r;

    assign stat_used = 32'h00ff_ffff;
    assign irq_set = wr_irq_en ? (bus_req_in.wdata & stat_used) : 32'h0000_0000;
    assign irq_clr = wr_irq_dis ? bus_req_in.wdata : 32'h0000_0000;

    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask_r <= periph_frontend_pkg::MASK_RST;
        end else begin
            irq_mask_r <= (irq_mask_r | irq_set) & ~irq_clr;
        end
    end

    // Status word: core bits low, end-of-transfer flags above, rest zero
    assign stat_word = {8'h00, eot_r, core_status_in};

    // Interrupt source toward the vectored_irq_controller
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            irq_source_out <= 1'b0;
        end else begin
            irq_source_out <= |(stat_word & irq_mask_r);
        end
    end

    // Two-entry buffer between the core and memory
    periph_frontend_pkg::xfer_word_t buf_mem_r [BUF_DEPTH];
    logic [PTR_W-1:0] buf_wr_r;
    logic [PTR_W-1:0] buf_rd_r;
    logic [PTR_W:0] buf_cnt_r;
    logic buf_full;
    logic push;
    logic pop;
    logic [31:0] ptr_r [NC];
    logic [periph_frontend_pkg::CNT_W-1:0] cnt_r [NC];
    logic [NC-1:0] chan_busy;

    assign buf_full = (buf_cnt_r == (PTR_W + 1)'(BUF_DEPTH));
    // A channel with nothing left stalls the core rather than dropping data
    assign core_ready_out = !buf_full && chan_busy[core_chan_in];
    assign push = core_valid_in && core_ready_out;
    assign mem_valid_out = (buf_cnt_r != '0);
    assign pop = mem_valid_out && mem_ready_in;
    assign mem_word_out = buf_mem_r[buf_rd_r];
    assign chan_active_out = chan_busy;

    // Buffer storage, with the channel address captured at push time
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < BUF_DEPTH; i++) begin
                buf_mem_r[i] <= '0;
            end
        end else if (push) begin
            buf_mem_r[buf_wr_r] <= '{chan: core_chan_in, addr: ptr_r[core_chan_in],
                                     data: core_data_in};
        end
    end

    // Buffer pointers and occupancy
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            buf_wr_r <= '0;
            buf_rd_r <= '0;
            buf_cnt_r <= '0;
        end else begin
            if (push) begin
                buf_wr_r <= (buf_wr_r == PTR_W'(BUF_DEPTH - 1)) ? '0 : buf_wr_r + 1'b1;
            end
            if (pop) begin
                buf_rd_r <= (buf_rd_r == PTR_W'(BUF_DEPTH - 1)) ? '0 : buf_rd_r + 1'b1;
            end
            if (push && !pop) begin
                buf_cnt_r <= buf_cnt_r + 1'b1;
            end else if (pop && !push) begin
                buf_cnt_r <= buf_cnt_r - 1'b1;
            end
        end
    end

    // Transfer channels, one receive and one transmit per serial peripheral
    genvar ch;
    generate
        for (ch = 0; ch < NC; ch++) begin : g_chan
            logic wr_ptr_c;
            logic wr_cnt_c;
            logic step_c;
            logic done_c;

            assign wr_ptr_c = wr_hit && chan_space && (chan_sel == 3'(ch))
                && (chan_field == periph_frontend_pkg::OFF_CHAN_PTR);
            assign wr_cnt_c = wr_hit && chan_space && (chan_sel == 3'(ch))
                && (chan_field == periph_frontend_pkg::OFF_CHAN_CNT);
            assign step_c = push && (core_chan_in == 3'(ch));
            assign done_c = step_c && (cnt_r[ch] == 16'h0001);
            assign chan_busy[ch] = (cnt_r[ch] != '0);

            // Pointer: a software write overrides a unit step in the same cycle
            always_ff @(posedge ref_clk_in or negedge rst_n) begin
                if (!rst_n) begin
                    ptr_r[ch] <= periph_frontend_pkg::PTR_RST;
                end else if (wr_ptr_c) begin
                    ptr_r[ch] <= bus_req_in.wdata;
                end else if (step_c) begin
                    ptr_r[ch] <= ptr_r[ch] + UNIT_BYTES;
                end
            end

            // Count: 16 bits caps one block at 65535 units
            always_ff @(posedge ref_clk_in or negedge rst_n) begin
                if (!rst_n) begin
                    cnt_r[ch] <= periph_frontend_pkg::CNT_RST;
                end else if (wr_cnt_c) begin
                    cnt_r[ch] <= bus_req_in.wdata[periph_frontend_pkg::CNT_W-1:0];
                end else if (step_c) begin
                    cnt_r[ch] <= cnt_r[ch] - 1'b1;
                end
            end

            // End-of-transfer flag; completion wins over the clear by a count write
            always_ff @(posedge ref_clk_in or negedge rst_n) begin
                if (!rst_n) begin
                    eot_r[ch] <= 1'b0;
                end else if (done_c) begin
                    eot_r[ch] <= 1'b1;
                end else if (wr_cnt_c) begin
                    eot_r[ch] <= 1'b0;
                end
            end
        end
    endgenerate

    // Read multiplexer; unused bits and unmapped words read zero
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (chan_space) begin
            if (chan_field == periph_frontend_pkg::OFF_CHAN_PTR) begin
                rd_mux = ptr_r[chan_sel];
            end else if (chan_field == periph_frontend_pkg::OFF_CHAN_CNT) begin
                rd_mux = {16'h0000, cnt_r[chan_sel]};
            end
        end else begin
            case (word_off)
                periph_frontend_pkg::OFF_MODE: rd_mux = mode_out;
                periph_frontend_pkg::OFF_STAT: rd_mux = stat_word;
                periph_frontend_pkg::OFF_SHADOW_ST: rd_mux = {16'h0000, shadow_status_out};
                periph_frontend_pkg::OFF_IRQ_MASK: rd_mux = irq_mask_r;
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // Answer one cycle after the request, for hits and misses alike
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            bus_ack_out <= 1'b0;
            bus_hit_out <= 1'b0;
            bus_rdata_out <= 32'h0000_0000;
        end else begin
            bus_ack_out <= bus_req_in.valid;
            bus_hit_out <= hit;
            bus_rdata_out <= rd_hit ? rd_mux : 32'h0000_0000;
        end
    end

endmodule : peripheral_reg_frontend
`default_nettype wire

// file: sim/frontend_checker_asserts.sv
// Checker for the peripheral register front end, bound to its top module
`timescale 1ns/100ps
`default_nettype none
module frontend_checker #(
    parameter logic [31:0] BASE_ADDR = 32'hfffc_0000,
    parameter bit IS_IRQ_CTRL = 1'b0,
    parameter logic [31:0] UNIT_BYTES = 32'h0000_0001,
    parameter int BUF_DEPTH = 2
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    // Register bus
    input wire periph_frontend_pkg::bus_req_t bus_req_in,
    input wire logic bus_ack_out,
    input wire logic bus_hit_out,
    input wire logic [31:0] bus_rdata_out,
    // Core side
    input wire logic [15:0] core_status_in,
    input wire logic [31:0] cmd_pulse_out,
    input wire logic [31:0] mode_out,
    input wire logic [15:0] shadow_status_out,
    input wire logic irq_source_out,
    input wire logic core_valid_in,
    input wire logic [2:0] core_chan_in,
    input wire logic [31:0] core_data_in,
    input wire logic core_ready_out,
    input wire logic [7:0] chan_active_out,
    // Memory side
    input wire logic mem_valid_out,
    input wire periph_frontend_pkg::xfer_word_t mem_word_out,
    input wire logic mem_ready_in
);
    localparam int WB = IS_IRQ_CTRL ? 12 : 14;
    logic hit_now;
    logic wr_hit;
    logic [11:0] woff;
    logic [23:0] mask_r;

    // Window decode and word offset of the current request
    assign hit_now = bus_req_in.valid && ((bus_req_in.addr >> WB) == (BASE_ADDR >> WB));
    assign wr_hit = hit_now && bus_req_in.write;
    assign woff = bus_req_in.addr[13:2];

    // Reference copy of the mask, so the source can be judged without reading it
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mask_r <= 24'h000000;
        end else if (wr_hit && woff == 12'h006) begin
            mask_r <= mask_r | bus_req_in.wdata[23:0];
        end else if (wr_hit && woff == 12'h007) begin
            mask_r <= mask_r & ~bus_req_in.wdata[23:0];
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!arst_n_in);

    ack_follows_req_a: assert property (bus_req_in.valid |=> bus_ack_out)
        else $error("no answer after a request");
    ack_only_req_a: assert property (bus_ack_out |-> $past(bus_req_in.valid))
        else $error("answer without a request");
    hit_decode_a: assert property (bus_req_in.valid |=> bus_hit_out == $past(hit_now))
        else $error("window decode wrong");
    ctrl_pulse_a: assert property (wr_hit && woff == 12'h000 |=> cmd_pulse_out == $past(bus_req_in.wdata))
        else $error("command pulse differs from written word");
    ctrl_quiet_a: assert property (!(wr_hit && woff == 12'h000) |=> cmd_pulse_out == 32'h0)
        else $error("command pulse without control write");
    mode_write_a: assert property (wr_hit && woff == 12'h001 |=> mode_out == $past(bus_req_in.wdata))
        else $error("mode not taken as a whole word");
    shadow_set_a: assert property (wr_hit && woff == 12'h003
        |=> shadow_status_out == ($past(shadow_status_out) | $past(bus_req_in.wdata[15:0])))
        else $error("enable write did not set bits");
    shadow_clr_a: assert property (wr_hit && woff == 12'h004
        |=> shadow_status_out == ($past(shadow_status_out) & ~$past(bus_req_in.wdata[15:0])))
        else $error("disable write did not clear bits");
    irq_mask_a: assert property ($past(mask_r[23:16]) == 8'h00
        |-> irq_source_out == $past(|(core_status_in & mask_r[15:0])))
        else $error("interrupt source not masked status");
    ready_count_a: assert property (core_ready_out |-> chan_active_out[core_chan_in])
        else $error("unit taken on an exhausted channel");
    mem_hold_a: assert property (mem_valid_out && !mem_ready_in |=> mem_valid_out && $stable(mem_word_out))
        else $error("stalled word lost or changed");
endmodule : frontend_checker

bind peripheral_reg_frontend frontend_checker #(.BASE_ADDR(BASE_ADDR), .IS_IRQ_CTRL(IS_IRQ_CTRL),
    .UNIT_BYTES(UNIT_BYTES), .BUF_DEPTH(BUF_DEPTH)) checker_i (.*);
`default_nettype wire

// file: sim/mem_sink_model.sv
// Memory side model that accepts buffered words and can stall on command
`timescale 1ns/100ps
`default_nettype none
module mem_sink_model (
    // Clock, reset and stall control
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic stall_in,
    // Word stream from the front end
    input wire logic valid_in,
    input wire periph_frontend_pkg::xfer_word_t word_in,
    output logic ready_out
);
    periph_frontend_pkg::xfer_word_t got [0:7];
    int n_got;

    // Ready drops only while the bench orders a stall
    assign ready_out = !stall_in;

    // Record each accepted word in arrival order
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            n_got <= 0;
        end else if (valid_in && ready_out) begin
            got[n_got[2:0]] <= word_in;
            n_got <= n_got + 1;
        end
    end
endmodule : mem_sink_model
`default_nettype wire

// file: sim/peripheral_reg_frontend_test.sv
// Self-checking bench for the peripheral register front end
`timescale 1ns/100ps
`default_nettype none
module peripheral_reg_frontend_test;
    typedef periph_frontend_pkg::acc_size_t sz_t;
    typedef struct packed {logic wr; sz_t sz; logic [31:0] a; logic [31:0] d; logic [31:0] r; logic h;} row_t;
    localparam logic [31:0] B = 32'hfffc_0000;
    localparam sz_t SW = periph_frontend_pkg::SIZE_WORD;
    localparam sz_t SH = periph_frontend_pkg::SIZE_HALF;
    localparam sz_t SB = periph_frontend_pkg::SIZE_BYTE;
    // Access, expected read data and expected hit
    localparam row_t ROWS [17] = '{
        '{1'b0, SW, B + 32'h4, 32'h0, 32'h0, 1'b1}, '{1'b1, SW, B + 32'h4, 32'h1234_5678, 32'h0, 1'b1},
        '{1'b1, SB, B + 32'h6, 32'hcafe_0001, 32'h0, 1'b1}, '{1'b0, SH, B + 32'h5, 32'h0, 32'hcafe_0001, 1'b1},
        '{1'b1, SW, B + 32'h8, 32'h0000_ff00, 32'h0, 1'b1}, '{1'b0, SW, B + 32'h8, 32'h0, 32'h0000_00a5, 1'b1},
        '{1'b1, SW, B + 32'hc, 32'h0000_0005, 32'h0, 1'b1}, '{1'b1, SW, B + 32'h10, 32'h0000_0004, 32'h0, 1'b1},
        '{1'b0, SW, B + 32'h14, 32'h0, 32'h0000_0001, 1'b1}, '{1'b0, SW, B + 32'hc, 32'h0, 32'h0, 1'b1},
        '{1'b1, SW, B + 32'h18, 32'h0000_ffff, 32'h0, 1'b1}, '{1'b0, SW, B + 32'h20, 32'h0, 32'h0000_ffff, 1'b1},
        '{1'b1, SW, B + 32'h1c, 32'h0000_ffff, 32'h0, 1'b1}, '{1'b0, SW, B + 32'h3ffc, 32'h0, 32'h0, 1'b1},
        '{1'b0, SW, B + 32'h4000, 32'h0, 32'h0, 1'b0}, '{1'b1, SW, B + 32'h104, 32'h0000_ffff, 32'h0, 1'b1},
        '{1'b0, SW, B + 32'h104, 32'h0, 32'h0000_ffff, 1'b1}};
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic stall = 1'b1;
    logic cvalid = 1'b0;
    logic [2:0] cchan = 3'h0;
    logic [31:0] cdata = 32'h0;
    logic [15:0] cstat = 16'h00a5;
    periph_frontend_pkg::bus_req_t req = '0;
    periph_frontend_pkg::xfer_word_t mword;
    logic ack, hit, irq, cready, mvalid, mready;
    logic [31:0] rdata, cmd, mode;
    logic [15:0] shadow;
    logic [7:0] active;
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;

    // Four-byte units so pointer steps are visible
    peripheral_reg_frontend #(.UNIT_BYTES(32'h0000_0004)) DUT (.ref_clk_in(clk), .arst_n_in(arst_n),
        .bus_req_in(req), .bus_ack_out(ack), .bus_hit_out(hit), .bus_rdata_out(rdata),
        .core_status_in(cstat), .cmd_pulse_out(cmd), .mode_out(mode), .shadow_status_out(shadow),
        .irq_source_out(irq), .core_valid_in(cvalid), .core_chan_in(cchan), .core_data_in(cdata),
        .core_ready_out(cready), .chan_active_out(active), .mem_valid_out(mvalid),
        .mem_word_out(mword), .mem_ready_in(mready));
    mem_sink_model snk (.clk_in(clk), .rst_n_in(arst_n), .stall_in(stall), .valid_in(mvalid),
        .word_in(mword), .ready_out(mready));

    // Clock
    always #2.5 clk = ~clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One bus access; the answer is due just after the edge that takes the request
    task automatic bus(input logic wr, input sz_t sz, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic h);
        @(posedge clk);
        req <= '{1'b1, wr, sz, a, d};
        @(posedge clk);
        req.valid <= 1'b0;
        #1;
        chk(ack, 1'b1);
        rd = rdata;
        h = hit;
    endtask : bus

    task automatic print_verdict();
        $display("compared=%0d errors=%0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict

    // Hang guard, well above the fewer than 100 cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            num_errors++;
            print_verdict();
        end
    end

    initial begin
        logic [31:0] rd;
        logic h;
        int k;
        repeat (5) @(posedge clk);
        #1;
        chk({mode[23:0], active}, 32'h0);
        @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        foreach (ROWS[i]) begin
            bus(ROWS[i].wr, ROWS[i].sz, ROWS[i].a, ROWS[i].d, rd, h);
            chk(h, ROWS[i].h);
            chk(rd, ROWS[i].r);
        end
        chk({mode[15:0], shadow}, 32'h0001_0001);
        bus(1'b1, SW, B, 32'h0000_0081, rd, h);
        chk(cmd, 32'h0000_0081);
        // Status bit 0 is set by the core, so unmasking it must raise the source a cycle later
        bus(1'b1, SW, B + 32'h18, 32'h0000_0001, rd, h);
        @(posedge clk);
        #1;
        chk(irq, 1'b1);
        bus(1'b1, SW, B + 32'h1c, 32'h0000_0001, rd, h);
        @(posedge clk);
        #1;
        chk(irq, 1'b0);
        // Three units on channel 2 while memory stalls, so the buffer fills up
        bus(1'b1, SW, B + 32'h110, 32'h0000_2000, rd, h);
        bus(1'b1, SW, B + 32'h114, 32'h0000_0003, rd, h);
        @(posedge clk);
        cchan <= 3'h2;
        fork
            begin
                repeat (8) @(posedge clk);
                #1;
                chk(cready, 1'b0);
                @(posedge clk);
                stall <= 1'b0;
            end
            for (int i = 0; i < 3; i++) begin
                cvalid <= 1'b1;
                cdata <= 32'h0000_00d0 + i;
                #1;
                k = 0;
                while (!cready && k < 50) begin
                    @(posedge clk);
                    #1;
                    k++;
                end
                @(posedge clk);
            end
        join
        cvalid <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk(snk.n_got, 3);
        for (int i = 0; i < 3; i++) begin
            chk(snk.got[i].addr, 32'h0000_2000 + 4 * i);
            chk(snk.got[i].data, 32'h0000_00d0 + i);
        end
        chk(active[2], 1'b0);
        bus(1'b0, SW, B + 32'h8, 32'h0, rd, h);
        chk(rd, 32'h0004_00a5);
        @(posedge clk);
        cvalid <= 1'b1;
        #1;
        chk(cready, 1'b0);
        print_verdict();
    end
endmodule : peripheral_reg_frontend_test
`default_nettype wire
